// ==== design/smi_ctrl.sv ====
// serial mac interface control, status, data path steering and interrupt
module smi_ctrl
   import smi_pkg::*;
#(
   parameter int WORD_W   = 10,
   parameter int AN0_CNT  = AN0_CYC,
   parameter int AN1_CNT  = AN1_CYC,
   parameter int AN2_CNT  = AN2_CYC,
   parameter int AN3_CNT  = AN3_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   output logic                   irq,
   // straps
   input  wire logic              strap_bit0,
   input  wire logic              strap_bit1,
   input  wire logic              strap_bit2,
   // mac side
   input  wire logic              mac_tx_err,
   output logic                   core_tx_err,
   input  wire logic              mac_lpi_req,
   output logic                   core_lpi_req,
   output logic                   non_eee_mode,
   // serializer / deserializer side
   input  wire logic [WORD_W-1:0] des_word,
   output logic [WORD_W-1:0]      core_rx_word,
   input  wire logic [WORD_W-1:0] core_tx_word,
   output logic [WORD_W-1:0]      ser_word,
   output logic                   if_enable,
   // word boundary logic
   input  wire logic [3:0]        auto_align_idx,
   input  wire logic              wb_align,
   input  wire logic              wb_sync,
   output logic [3:0]             align_idx_sel,
   // transmit packet read-out
   input  wire logic              tx_pkt_req,
   input  wire logic              tx_even,
   output logic                   tx_read_start,
   // negotiation and link
   input  wire logic              an_page_in,
   input  wire logic              link_up_in,
   output logic                   an_running,
   // eee timers
   output logic [4:0]             tx_lpi_timer_r,
   output logic [4:0]             tx_lpi_timer_q,
   output logic [4:0]             tx_lpi_timer_s,
   output logic [3:0]             rx_quiet_code
);
   typedef struct packed {
      logic [DATA_W-1:0] ctrl;
      logic [DATA_W-1:0] eee_tx;
      logic [3:0]        eee_rx;
      logic [IRQ_N-1:0]  irq_stat;
      logic [IRQ_N-1:0]  irq_mask;
      logic              page_rx;
      logic              an_done;
      logic              link_q;
      logic [DATA_W-1:0] rdata;
      logic              tx_pend;
      logic              tx_start;
      logic              tx_err;
      logic [WORD_W-1:0] rx_word;
      logic [WORD_W-1:0] tx_word;
      logic [3:0]        idx;
   } smi_st_t;

   smi_st_t st_reg;
   smi_st_t st_next;

   logic              strap_load;
   logic              strap_en;
   logic              tmr_busy;
   logic              tmr_exp;
   logic              tmr_start;
   logic              tmr_abort;
   logic [TMR_W-1:0]  tmr_load;
   logic              link_now;
   logic              an_en;
   logic [WORD_W-1:0] des_ord;
   logic [WORD_W-1:0] tx_inv;
   logic [DATA_W-1:0] status_view;
   logic [IRQ_N-1:0]  ev;

   smi_strap u_strap (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .strap_val  ({strap_bit2, strap_bit1, strap_bit0}),
      .strap_load (strap_load),
      .strap_en   (strap_en)
   );

   smi_an_timer #(
      .CW (TMR_W)
   ) u_an_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (tmr_start),
      .abort   (tmr_abort),
      .load    (tmr_load),
      .busy    (tmr_busy),
      .expired (tmr_exp)
   );

   assign an_en    = st_reg.ctrl[B_AN_EN];
   assign link_now = link_up_in & st_reg.ctrl[B_IF_EN];

   // timer length from the select field
   always_comb begin
      unique case (st_reg.ctrl[F_ANT_HI:F_ANT_LO])
         2'b00:   tmr_load = TMR_W'(AN0_CNT);
         2'b01:   tmr_load = TMR_W'(AN1_CNT);
         2'b10:   tmr_load = TMR_W'(AN2_CNT);
         default: tmr_load = TMR_W'(AN3_CNT);
      endcase
   end

   // every new page restarts the wait; link loss or disable cancels it
   assign tmr_start = an_page_in & an_en & link_now;
   assign tmr_abort = ~an_en | ~link_now;

   // deserializer word order into the core; both bits of the field set = reverse
   generate
      for (genvar i = 0; i < WORD_W; i++) begin : g_ord
         always_comb begin
            if (st_reg.ctrl[F_TXORD_HI] & st_reg.ctrl[F_TXORD_LO]) begin
               des_ord[i] = des_word[WORD_W-1-i];
            end else begin
               des_ord[i] = des_word[i];
            end
         end
      end
   endgenerate

   assign tx_inv = st_reg.ctrl[B_TX_INV] ? ~core_tx_word : core_tx_word;

   always_comb begin
      status_view                      = '0;
      status_view[B_PAGE_RX]           = st_reg.page_rx;
      status_view[B_LINK_UP]           = link_now;
      status_view[B_AN_DONE]           = st_reg.an_done;
      status_view[B_ALIGN]             = wb_align;
      status_view[B_SYNC]              = wb_sync;
      status_view[F_CIDX_HI:F_CIDX_LO] = st_reg.idx;
   end

   assign ev[I_PAGE]    = an_page_in & st_reg.ctrl[B_IF_EN];
   assign ev[I_LINK]    = link_now ^ st_reg.link_q;
   assign ev[I_AN_DONE] = tmr_exp & an_en & link_now;

   always_comb begin
      st_next          = st_reg;
      st_next.tx_start = 1'b0;
      st_next.rdata    = '0;
      st_next.link_q   = link_now;

      // interface enable default arrives two cycles after release
      if (strap_load) begin
         st_next.ctrl[B_IF_EN] = strap_en;
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CTRL:     st_next.ctrl   = reg_wdata;
            OFS_EEE_TX:   st_next.eee_tx = reg_wdata;
            OFS_EEE_RX:   st_next.eee_rx = reg_wdata[3:0];
            OFS_IRQ_MASK: st_next.irq_mask = reg_wdata[IRQ_N-1:0];
            OFS_IRQ_STAT: st_next.irq_stat =
                             st_reg.irq_stat & ~reg_wdata[IRQ_N-1:0];
            default:      ;
         endcase
      end

      // register reads, data valid in the next cycle
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL:     st_next.rdata = st_reg.ctrl;
            OFS_EEE_TX:   st_next.rdata = st_reg.eee_tx;
            OFS_STATUS: begin
               st_next.rdata   = status_view;
               st_next.page_rx = 1'b0;
            end
            OFS_EEE_RX:   st_next.rdata = {12'h000, st_reg.eee_rx};
            OFS_IRQ_STAT: st_next.rdata = {13'h0000, st_reg.irq_stat};
            OFS_IRQ_MASK: st_next.rdata = {13'h0000, st_reg.irq_mask};
            default:      st_next.rdata = '0;
         endcase
      end

      // a page landing on the read cycle survives the clear
      if (ev[I_PAGE]) begin
         st_next.page_rx = 1'b1;
      end
      st_next.irq_stat = st_next.irq_stat | ev;

      // negotiation completes on timer expiry; lost on link drop or disable
      if (tmr_abort) begin
         st_next.an_done = 1'b0;
      end else if (tmr_exp) begin
         st_next.an_done = 1'b1;
      end

      // boundary index: forced value or the automatic choice
      st_next.idx = st_reg.ctrl[B_IDX_FORCE] ?
                    st_reg.ctrl[F_IDX_HI:F_IDX_LO] : auto_align_idx;

      st_next.tx_err = mac_tx_err & ~st_reg.ctrl[B_TXERR_DIS]
                       & st_reg.ctrl[B_IF_EN];

      // disabled interface drives quiet words both ways
      if (st_reg.ctrl[B_IF_EN]) begin
         st_next.rx_word = st_reg.ctrl[B_RX_INV] ? ~des_ord : des_ord;
         for (int i = 0; i < WORD_W; i++) begin
            st_next.tx_word[i] = st_reg.ctrl[B_RX_ORDER] ?
                                 tx_inv[WORD_W-1-i] : tx_inv[i];
         end
      end else begin
         st_next.rx_word = '0;
         st_next.tx_word = '0;
      end

      // packet read start waits for the even slot when aligning
      if (!st_reg.ctrl[B_IF_EN]) begin
         st_next.tx_pend = 1'b0;
      end else if (st_reg.ctrl[B_PKT_ALIGN]) begin
         if ((tx_pkt_req | st_reg.tx_pend) & tx_even) begin
            st_next.tx_start = 1'b1;
            st_next.tx_pend  = 1'b0;
         end else if (tx_pkt_req) begin
            st_next.tx_pend  = 1'b1;
         end
      end else begin
         st_next.tx_start = tx_pkt_req | st_reg.tx_pend;
         st_next.tx_pend  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg          <= '0;
         st_reg.ctrl     <= RST_CTRL;
         st_reg.eee_tx   <= RST_EEE_TX;
         st_reg.eee_rx   <= RST_EEE_RX;
         st_reg.irq_mask <= RST_IRQ_MASK;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata      = st_reg.rdata;
   // level interrupt while any unmasked sticky bit stands
   assign irq            = |(st_reg.irq_stat & st_reg.irq_mask);
   assign core_tx_err    = st_reg.tx_err;
   assign non_eee_mode   = st_reg.eee_tx[B_NON_EEE];
   // core never sees a low-power request from a mac without eee support
   assign core_lpi_req   = mac_lpi_req & ~st_reg.eee_tx[B_NON_EEE];
   assign core_rx_word   = st_reg.rx_word;
   assign ser_word       = st_reg.tx_word;
   assign if_enable      = st_reg.ctrl[B_IF_EN];
   assign align_idx_sel  = st_reg.idx;
   assign tx_read_start  = st_reg.tx_start;
   assign an_running     = tmr_busy;
   assign tx_lpi_timer_r = st_reg.eee_tx[F_TR_HI:F_TR_LO];
   assign tx_lpi_timer_q = st_reg.eee_tx[F_TQ_HI:F_TQ_LO];
   assign tx_lpi_timer_s = st_reg.eee_tx[F_TS_HI:F_TS_LO];
   assign rx_quiet_code  = st_reg.eee_rx;
endmodule : smi_ctrl

// ==== design/smi_pkg.sv ====
// constants and register map for the serial mac interface control block
//
// Behaviour
// - bit 15 of the control register, reset 0, when set blocks the transmit error from the mac.
// - bit 14 of the control register, when set, replaces the automatic word boundary with the software index.
// - bits 13-10 of the control register hold the forced boundary index, used only while bit 14 is set.
// - bit 9 of the control register resets to 1 only if the three strap inputs read 000, else 0, and gates the interface.
// - bit 8 of the control register inverts the incoming receive word before it is decoded.
// - bit 7 of the control register inverts the outgoing transmit word.
// - bits 6-5 of the control register, reset 11, choose the bit order of deserializer data entering the core.
// - bit 4 of the control register, reset 1, sends data leaving the core msb first at 0 and lsb first at 1.
// - bit 3 of the control register, reset 1, holds each transmit read start until the even code-group pulse.
// - bits 2-1 of the control register pick the negotiation timer, 00 1.6ms, 01 2us, 10 800us, 11 11ms, reset 01.
// - bit 0 of the control register, reset 1, runs auto-negotiation when 1 and skips it when 0.
// - bit 0 of the eee timer register turns on the mode for a mac without energy-efficient support.
// - bit 12 of the status register is set by a new negotiation page while bit 9 is set and cleared when software reads it.
// - bit 11 of the status register reads 1 while the serial link is up and bit 9 is set, and 0 otherwise.
// - bit 10 of the status register reads 1 once negotiation has completed, and 0 before then or after link loss or disable.
// - bits 9 and 8 of the status register show the boundary align and sync indications.
// - bits 7-4 of the status register show the boundary index currently in use.
package smi_pkg;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 16;
   localparam logic [15:0] OFS_CTRL       = 16'h0608;
   localparam logic [15:0] OFS_EEE_TX     = 16'h0609;
   localparam logic [15:0] OFS_STATUS     = 16'h060a;
   localparam logic [15:0] OFS_EEE_RX     = 16'h060b;
   localparam logic [15:0] OFS_IRQ_STAT   = 16'h0620;
   localparam logic [15:0] OFS_IRQ_MASK   = 16'h0621;
   localparam logic [15:0] RST_CTRL       = 16'h007b;
   localparam logic [15:0] RST_EEE_TX     = 16'h0000;
   localparam logic [3:0]  RST_EEE_RX     = 4'h5;
   localparam logic [2:0]  RST_IRQ_MASK   = 3'h0;
   localparam logic [2:0]  STRAP_EN_CODE  = 3'h0;
   // control register fields
   localparam int          B_TXERR_DIS    = 15;
   localparam int          B_IDX_FORCE    = 14;
   localparam int          F_IDX_HI       = 13;
   localparam int          F_IDX_LO       = 10;
   localparam int          B_IF_EN        = 9;
   localparam int          B_RX_INV       = 8;
   localparam int          B_TX_INV       = 7;
   localparam int          F_TXORD_HI     = 6;
   localparam int          F_TXORD_LO     = 5;
   localparam int          B_RX_ORDER     = 4;
   localparam int          B_PKT_ALIGN    = 3;
   localparam int          F_ANT_HI       = 2;
   localparam int          F_ANT_LO       = 1;
   localparam int          B_AN_EN        = 0;
   // eee transmit timer fields
   localparam int          F_TR_HI        = 15;
   localparam int          F_TR_LO        = 11;
   localparam int          F_TQ_HI        = 10;
   localparam int          F_TQ_LO        = 6;
   localparam int          F_TS_HI        = 5;
   localparam int          F_TS_LO        = 1;
   localparam int          B_NON_EEE      = 0;
   // status register fields
   localparam int          B_PAGE_RX      = 12;
   localparam int          B_LINK_UP      = 11;
   localparam int          B_AN_DONE      = 10;
   localparam int          B_ALIGN        = 9;
   localparam int          B_SYNC         = 8;
   localparam int          F_CIDX_HI      = 7;
   localparam int          F_CIDX_LO      = 4;
   // interrupt bits
   localparam int          I_PAGE         = 0;
   localparam int          I_LINK         = 1;
   localparam int          I_AN_DONE      = 2;
   localparam int          IRQ_N          = 3;
   // timer durations and cycle counts at the core clock
   localparam int          CLK_HZ         = 25_000_000;
   localparam int          T_AN0_NS       = 1_600_000;
   localparam int          T_AN1_NS       = 2_000;
   localparam int          T_AN2_NS       = 800_000;
   localparam int          T_AN3_NS       = 11_000_000;
   localparam int          TMR_W          = 20;
   localparam longint      NS_PER_S       = 64'd1_000_000_000;
   localparam int AN0_CYC = int'((longint'(T_AN0_NS) * CLK_HZ) / NS_PER_S);
   localparam int AN1_CYC = int'((longint'(T_AN1_NS) * CLK_HZ) / NS_PER_S);
   localparam int AN2_CYC = int'((longint'(T_AN2_NS) * CLK_HZ) / NS_PER_S);
   localparam int AN3_CYC = int'((longint'(T_AN3_NS) * CLK_HZ) / NS_PER_S);
endpackage : smi_pkg

// ==== design/smi_strap.sv ====
// captures the interface enable default from the strap inputs after reset
module smi_strap
   import smi_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] strap_val,
   output logic            strap_load,
   output logic            strap_en
);
   typedef struct packed {
      logic done;
      logic load;
      logic en;
   } smi_strap_st_t;

   smi_strap_st_t st_reg;
   smi_strap_st_t st_next;

   // sampled once, in the first clocked cycle after release
   always_comb begin
      st_next      = st_reg;
      st_next.load = 1'b0;
      if (!st_reg.done) begin
         st_next.done = 1'b1;
         st_next.load = 1'b1;
         st_next.en   = (strap_val == STRAP_EN_CODE);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign strap_load = st_reg.load;
   assign strap_en   = st_reg.en;
endmodule : smi_strap

// ==== design/smi_an_timer.sv ====
// auto-negotiation timer: loads a cycle count on start, pulses on expiry
module smi_an_timer
   import smi_pkg::*;
#(
   parameter int CW = TMR_W
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic          abort,
   input  wire logic [CW-1:0] load,
   output logic               busy,
   output logic               expired
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          busy;
      logic          exp;
   } smi_tmr_st_t;

   smi_tmr_st_t st_reg;
   smi_tmr_st_t st_next;

   always_comb begin
      st_next     = st_reg;
      st_next.exp = 1'b0;
      if (abort) begin
         st_next.busy = 1'b0;
      end else if (start) begin
         st_next.busy = 1'b1;
         st_next.cnt  = (load == '0) ? CW'(1) : load;
      end else if (st_reg.busy) begin
         if (st_reg.cnt == CW'(1)) begin
            st_next.busy = 1'b0;
            st_next.exp  = 1'b1;
         end
         st_next.cnt = st_reg.cnt - CW'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy    = st_reg.busy;
   assign expired = st_reg.exp;
endmodule : smi_an_timer

// ==== test/smi_ctrl_sva.sv ====
// assertion checker bound to the serial mac interface control block
module smi_ctrl_sva
   import smi_pkg::*;
#(
   parameter int WORD_W = 10
) (
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              strap_bit0,
   input wire logic              strap_bit1,
   input wire logic              strap_bit2,
   input wire logic              mac_tx_err,
   input wire logic              core_tx_err,
   input wire logic              mac_lpi_req,
   input wire logic              core_lpi_req,
   input wire logic              non_eee_mode,
   input wire logic              if_enable,
   input wire logic [WORD_W-1:0] core_rx_word,
   input wire logic [WORD_W-1:0] ser_word,
   input wire logic              wb_align,
   input wire logic              wb_sync,
   input wire logic              link_up_in,
   input wire logic              tx_pkt_req,
   input wire logic              tx_even,
   input wire logic              tx_read_start,
   input wire logic              an_page_in,
   input wire logic              an_running,
   input wire logic              irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic       st_rd;
   logic       st_link;
   logic [1:0] st_wb;
   logic [1:0] rel_cnt;
   // status fields are sampled at the read edge, checked a cycle later
   always_ff @(posedge ref_clk) begin
      st_rd   <= reg_rd && reg_addr == OFS_STATUS;
      st_link <= link_up_in && if_enable;
      st_wb   <= {wb_align, wb_sync};
      rel_cnt <= !rst_n ? 2'h0 : rel_cnt + {1'h0, rel_cnt != 2'h3};
   end
   a_txerr_gate: assert property (
      core_tx_err |-> $past(mac_tx_err) && $past(if_enable))
      else $error("tx error passed while blocked");
   a_off_quiet: assert property (
      !$past(if_enable) |-> core_rx_word == '0 && ser_word == '0)
      else $error("data moved while interface off");
   a_strap_dflt: assert property (
      rel_cnt == 2'h2 |-> if_enable ==
         ({strap_bit2, strap_bit1, strap_bit0} == STRAP_EN_CODE))
      else $error("interface enable default wrong");
   a_lpi_block: assert property (
      core_lpi_req == (mac_lpi_req && !non_eee_mode))
      else $error("lpi request steering wrong");
   a_pkt_cause: assert property (
      tx_read_start |-> $past(tx_pkt_req) || $past(tx_even))
      else $error("read start without request or even slot");
   a_an_cause: assert property (
      $rose(an_running) |-> $past(an_page_in))
      else $error("negotiation timer started without page");
   a_rd_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside answer cycle");
   a_link_bit: assert property (
      st_rd |-> reg_rdata[B_LINK_UP] == st_link)
      else $error("link bit wrong");
   a_wb_bits: assert property (
      st_rd |-> reg_rdata[B_ALIGN:B_SYNC] == st_wb && reg_rdata[15:13] == '0)
      else $error("boundary flags wrong");
   c_an_run: cover property ($rose(an_running));
   c_pkt: cover property (tx_read_start);
   c_irq: cover property ($rose(irq));
endmodule : smi_ctrl_sva

bind smi_ctrl smi_ctrl_sva #(.WORD_W(WORD_W)) i_sva (.ref_clk, .rst_n,
   .reg_addr, .reg_rd, .reg_rdata, .strap_bit0, .strap_bit1, .strap_bit2,
   .mac_tx_err, .core_tx_err, .mac_lpi_req, .core_lpi_req, .non_eee_mode,
   .if_enable, .core_rx_word, .ser_word, .wb_align, .wb_sync, .link_up_in,
   .tx_pkt_req, .tx_even, .tx_read_start, .an_page_in, .an_running, .irq);

// ==== test/smi_mac_model.sv ====
// behavioural mac driving transmit error and low power request
module smi_mac_model (
   input  wire logic ref_clk,
   input  wire logic err_cmd,
   input  wire logic lpi_cmd,
   output logic      mac_tx_err = 1'h0,
   output logic      mac_lpi_req = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // launched just after the edge, like a registered mac output
   always @(posedge ref_clk) begin
      mac_tx_err  <= err_cmd;
      mac_lpi_req <= lpi_cmd;
   end
endmodule : smi_mac_model

// ==== test/smi_ctrl_tb.sv ====
// self-checking bench for the serial mac interface control block
module smi_ctrl_tb
   import smi_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 10;
   localparam int AN_CNT [4] = '{40, 5, 20, 60};
   logic           ref_clk = 1'h0, rst_n = 1'h0, irq;
   logic [15:0]    reg_addr = '0, reg_wdata = '0, reg_rdata;
   logic           reg_wr = 1'h0, reg_rd = 1'h0, err_cmd = 1'h0;
   logic           strap_bit0 = 1'h0, strap_bit1 = 1'h0, strap_bit2 = 1'h0;
   logic           lpi_cmd = 1'h0, mac_tx_err, mac_lpi_req, if_enable;
   logic           core_tx_err, core_lpi_req, non_eee_mode, an_running;
   logic [W-1:0]   des_word = '0, core_tx_word = '0, core_rx_word, ser_word;
   logic [3:0]     auto_align_idx = 4'h5, align_idx_sel, rx_quiet_code;
   logic           wb_align = 1'h0, wb_sync = 1'h0, tx_pkt_req = 1'h0;
   logic           tx_even = 1'h0, an_page_in = 1'h0, link_up_in = 1'h0;
   logic           tx_read_start;
   logic [4:0]     tx_lpi_timer_r, tx_lpi_timer_q, tx_lpi_timer_s;
   int             n_errors = 0, check_count = 0;
   always #20 ref_clk = ~ref_clk;
   smi_mac_model i_mac (.ref_clk, .err_cmd, .lpi_cmd, .mac_tx_err,
      .mac_lpi_req);
   smi_ctrl #(.WORD_W(W), .AN0_CNT(40), .AN1_CNT(5), .AN2_CNT(20),
      .AN3_CNT(60)) i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .irq, .strap_bit0, .strap_bit1,
      .strap_bit2, .mac_tx_err, .core_tx_err, .mac_lpi_req, .core_lpi_req,
      .non_eee_mode, .des_word, .core_rx_word, .core_tx_word, .ser_word,
      .if_enable, .auto_align_idx, .wb_align, .wb_sync, .align_idx_sel,
      .tx_pkt_req, .tx_even, .tx_read_start, .an_page_in, .link_up_in,
      .an_running, .tx_lpi_timer_r, .tx_lpi_timer_q, .tx_lpi_timer_s,
      .rx_quiet_code);
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic wr(logic [15:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rchk(string nm, logic [15:0] a, logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 chk(nm, e, reg_rdata);
   endtask : rchk
   task automatic t_reset();
      rchk("ctrl", OFS_CTRL, RST_CTRL | 16'h0200);
      rchk("eee_tx", OFS_EEE_TX, RST_EEE_TX);
      rchk("status", OFS_STATUS, 16'h0050);
      rchk("eee_rx", OFS_EEE_RX, {12'h000, RST_EEE_RX});
      chk("quiet", 16'(RST_EEE_RX), 16'(rx_quiet_code));
      wr(16'h0700, 16'hffff);
      rchk("unmapped", 16'h0700, 16'h0000);
      wr(OFS_STATUS, 16'hffff);
      rchk("status_ro", OFS_STATUS, 16'h0050);
      $display("test reset done");
   endtask : t_reset
   task automatic t_data();
      logic [W-1:0] d, t, e;
      d = 10'h2c5;
      t = 10'h0f3;
      wr(OFS_CTRL, 16'h027b);
      des_word <= d;
      core_tx_word <= t;
      @(posedge ref_clk);
      e = {<<{d}};
      #1 chk("rx_rev", 16'(e), 16'(core_rx_word));
      e = {<<{t}};
      chk("tx_rev", 16'(e), 16'(ser_word));
      wr(OFS_CTRL, 16'h0381);
      @(posedge ref_clk);
      e = ~d;
      #1 chk("rx_inv", 16'(e), 16'(core_rx_word));
      e = ~t;
      chk("tx_inv", 16'(e), 16'(ser_word));
      wr(OFS_CTRL, 16'h007b);
      @(posedge ref_clk);
      #1 chk("rx_off", 16'h0000, 16'(core_rx_word));
      $display("test data done");
   endtask : t_data
   task automatic t_side();
      wr(OFS_CTRL, 16'h027b);
      err_cmd <= 1'h1;
      cyc(3);
      #1 chk("txerr_on", 16'h0001, 16'(core_tx_err));
      wr(OFS_CTRL, 16'h827b);
      @(posedge ref_clk);
      #1 chk("txerr_dis", 16'h0000, 16'(core_tx_err));
      @(posedge ref_clk);
      lpi_cmd <= 1'h1;
      wr(OFS_EEE_TX, 16'h5a5b);
      #1 chk("non_eee", 16'h0001, 16'(non_eee_mode));
      chk("lpi_blk", 16'h0000, 16'(core_lpi_req));
      chk("timers", 16'h2d2d, {1'h0, tx_lpi_timer_r, tx_lpi_timer_q,
         tx_lpi_timer_s});
      rchk("eee_rb", OFS_EEE_TX, 16'h5a5b);
      wr(OFS_EEE_TX, 16'h5a5a);
      #1 chk("lpi_pass", 16'h0001, 16'(core_lpi_req));
      $display("test side done");
   endtask : t_side
   task automatic t_idx();
      wr(OFS_CTRL, 16'h6a7b);
      @(posedge ref_clk);
      #1 chk("idx_force", 16'h000a, 16'(align_idx_sel));
      rchk("st_idx", OFS_STATUS, 16'h00a0);
      wr(OFS_CTRL, 16'h2a7b);
      @(posedge ref_clk);
      #1 chk("idx_auto", 16'h0005, 16'(align_idx_sel));
      @(posedge ref_clk);
      wb_align <= 1'h1;
      rchk("st_wb", OFS_STATUS, 16'h0250);
      @(posedge ref_clk);
      wb_align <= 1'h0;
      wb_sync <= 1'h1;
      rchk("st_sync", OFS_STATUS, 16'h0150);
      @(posedge ref_clk);
      wb_sync <= 1'h0;
      $display("test index done");
   endtask : t_idx
   task automatic t_an();
      int n;
      wr(OFS_IRQ_MASK, 16'h0007);
      link_up_in <= 1'h1;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_CTRL, 16'h0279 | 16'(c << 1));
         @(posedge ref_clk);
         an_page_in <= 1'h1;
         @(posedge ref_clk);
         an_page_in <= 1'h0;
         n = 0;
         repeat (100) begin
            #1 n += int'(an_running === 1'h1);
            @(posedge ref_clk);
         end
         chk("an_len", 16'h0001, 16'(n >= AN_CNT[c] - 1 &&
            n <= AN_CNT[c] + 1));
      end
      rchk("st_page", OFS_STATUS, 16'h1c50);
      rchk("st_clr", OFS_STATUS, 16'h0c50);
      rchk("irq_stat", OFS_IRQ_STAT, 16'h0007);
      chk("irq_on", 16'h0001, 16'(irq));
      wr(OFS_IRQ_MASK, 16'h0000);
      #1 chk("irq_mask", 16'h0000, 16'(irq));
      wr(OFS_IRQ_STAT, 16'h0007);
      rchk("irq_w1c", OFS_IRQ_STAT, 16'h0000);
      wr(OFS_CTRL, 16'h027a);
      rchk("an_off", OFS_STATUS, 16'h0850);
      @(posedge ref_clk);
      an_page_in <= 1'h1;
      @(posedge ref_clk);
      an_page_in <= 1'h0;
      cyc(2);
      #1 chk("an_skip", 16'h0000, 16'(an_running));
      $display("test negotiation done");
   endtask : t_an
   task automatic t_align();
      wr(OFS_CTRL, 16'h027b);
      tx_pkt_req <= 1'h1;
      @(posedge ref_clk);
      tx_pkt_req <= 1'h0;
      cyc(2);
      tx_even <= 1'h1;
      #1 chk("no_early", 16'h0000, 16'(tx_read_start));
      @(posedge ref_clk);
      tx_even <= 1'h0;
      #1 chk("even_start", 16'h0001, 16'(tx_read_start));
      wr(OFS_CTRL, 16'h0273);
      tx_pkt_req <= 1'h1;
      @(posedge ref_clk);
      tx_pkt_req <= 1'h0;
      #1 chk("free_start", 16'h0001, 16'(tx_read_start));
      $display("test align done");
   endtask : t_align
   task automatic t_strap();
      @(posedge ref_clk);
      strap_bit0 <= 1'h1;
      rst_n <= 1'h0;
      cyc(3);
      rst_n <= 1'h1;
      cyc(3);
      rchk("ctrl_strap", OFS_CTRL, RST_CTRL);
      $display("test strap done");
   endtask : t_strap
   initial begin
      cyc(3);
      rst_n <= 1'h1;
      cyc(3);
      t_reset();
      t_data();
      t_side();
      t_idx();
      t_an();
      t_align();
      t_strap();
      print_verdict();
   end
   initial begin
      cyc(20000);
      n_errors++;
      $display("BAD run expected end seen timeout");
      print_verdict();
   end
endmodule : smi_ctrl_tb
